/* rtl/hes_pkg.sv */
/*
  Constants, command codes and field layout for the host event status
  block: the device end and the processor end both use them.
  Assumes one 20 MHz clock shared by both ends and an active-low reset.
*/
// Behaviour
// - Pending bit drives pin if enabled and gated
// - Status read returns bits, clears nothing
// - Write-one clears bit, zero leaves it
// - Driver acknowledges all by writing FFH
// - Bit 6 on clock ready after wake-up
// - Bit 5 when host enters suspend
// - Control write suspends; then frame starts stop
// - Bit 4 on operational register attention
// - Bit 2 on internal or external transfer end
// - Bit 1 when async list data ready
// - Bit 0 at each frame start
// - Mask shares bit layout, resets to zero
// - Setup bits: gate, trigger mode, polarity
// - Byte count match raises internal transfer end
package hes_pkg;

  localparam int unsigned DATA_W        = 16;
  localparam int unsigned CODE_W        = 8;
  localparam int unsigned EVT_W         = 7;
  localparam int unsigned CLK_HZ        = 20_000_000;

  // Command codes: read code, write code is read code with bit 7 set
  localparam logic [7:0] CMD_WRITE_FLAG = 8'h80;
  localparam logic [7:0] CMD_CTRL_RD    = 8'h01;
  localparam logic [7:0] CMD_SETUP_RD   = 8'h20;
  localparam logic [7:0] CMD_COUNT_RD   = 8'h22;
  localparam logic [7:0] CMD_STATUS_RD  = 8'h24;
  localparam logic [7:0] CMD_MASK_RD    = 8'h25;
  localparam logic [7:0] CMD_BUDGET_RD  = 8'h1b;
  localparam logic [7:0] CMD_STATUS_WR  = 8'ha4;

  // Status and mask bit positions
  localparam int unsigned EV_FRAME      = 0;
  localparam int unsigned EV_ASYNC      = 1;
  localparam int unsigned EV_DONE       = 2;
  localparam int unsigned EV_OPR        = 4;
  localparam int unsigned EV_SUSPEND    = 5;
  localparam int unsigned EV_CLKRDY     = 6;
  localparam logic [6:0]  EVT_IMPL_MASK = 7'h77;
  localparam logic [6:0]  EVT_RESET     = 7'h00;
  localparam logic [15:0] ACK_ALL_VALUE = 16'h00ff;

  // Hardware setup bits
  localparam int unsigned SETUP_GATE    = 0;
  localparam int unsigned SETUP_EDGE    = 1;
  localparam int unsigned SETUP_POL     = 2;
  localparam int unsigned SETUP_W       = 3;
  localparam logic [2:0]  SETUP_RESET   = 3'h0;

  // Host control functional state field
  localparam int unsigned CTRL_FS_LSB   = 6;
  localparam logic [1:0]  CTRL_FS_SUSP  = 2'h3;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;

  // Timing
  localparam int unsigned WAKE_MAX_US   = 1000;
  localparam int unsigned WAKE_MAX_CYC  = WAKE_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned IRQ_PULSE_CYC = 4;
  localparam int unsigned PHASE_CYC     = 8;

  typedef enum logic [2:0] {
    HES_SEL_NONE   = 3'b000,
    HES_SEL_STATUS = 3'b001,
    HES_SEL_MASK   = 3'b010,
    HES_SEL_SETUP  = 3'b011,
    HES_SEL_COUNT  = 3'b100,
    HES_SEL_CTRL   = 3'b101,
    HES_SEL_BUDGET = 3'b110
  } hes_sel_t;

  function automatic hes_sel_t hes_decode(input logic [7:0] code);
    logic [7:0] base;
    base = code & ~CMD_WRITE_FLAG;
    case (base)
      CMD_STATUS_RD: hes_decode = HES_SEL_STATUS;
      CMD_MASK_RD:   hes_decode = HES_SEL_MASK;
      CMD_SETUP_RD:  hes_decode = HES_SEL_SETUP;
      CMD_COUNT_RD:  hes_decode = HES_SEL_COUNT;
      CMD_CTRL_RD:   hes_decode = HES_SEL_CTRL;
      CMD_BUDGET_RD: hes_decode = HES_SEL_BUDGET;
      default:       hes_decode = HES_SEL_NONE;
    endcase
  endfunction : hes_decode

endpackage : hes_pkg

/* rtl/hes_bus_if.sv */
/*
  Shared parallel bus between processor end and device end.
  Assumes each end drives the data lines only with its enable low;
  undriven lines read as all ones, as with pull-ups.
*/
interface hes_bus_if;
  import hes_pkg::*;

  logic              cs_n;
  logic              rd_n;
  logic              wr_n;
  logic              a0;
  logic [DATA_W-1:0] host_d;
  logic              host_oe_n;
  logic [DATA_W-1:0] dev_d;
  logic              dev_oe_n;
  logic [DATA_W-1:0] data;
  logic              irq_pin;

  assign data = !dev_oe_n  ? dev_d  :
                !host_oe_n ? host_d : {DATA_W{1'b1}};

  modport dev
  (
    input  cs_n, rd_n, wr_n, a0, data,
    output dev_d, dev_oe_n, irq_pin
  );

  modport host
  (
    output cs_n, rd_n, wr_n, a0, host_d, host_oe_n,
    input  data, irq_pin
  );
endinterface : hes_bus_if

/* rtl/hes_dev.sv */
/*
  Device end: command decoder on the parallel bus, event status with
  write-one clear, mask, setup, byte counter and interrupt pin.
  Assumes bus pins are asynchronous to sys_clk_i; event inputs other
  than the external transfer end come from logic on sys_clk_i.
*/
module hes_dev
  import hes_pkg::*;
#(
  parameter int unsigned WAKE_MAX = hes_pkg::WAKE_MAX_CYC
)
(
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  // Bus side
  hes_bus_if.dev                         bus,
  // Event sources
  input  wire logic                      wakeup_i,
  input  wire logic                      clk_stable_i,
  input  wire logic                      downstream_susp_i,
  input  wire logic                      frame_tick_i,
  input  wire logic                      opr_evt_i,
  input  wire logic                      atl_pending_i,
  input  wire logic                      xfer_byte_i,
  input  wire logic                      ext_eot_n_i,
  // Status outputs
  output logic                           sof_o,
  output logic                           suspended_o,
  output logic [hes_pkg::EVT_W-1:0]      status_o
);
  import hes_pkg::*;

  localparam int unsigned SYNC_W = DATA_W + 5;

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic              wr_prev_reg;
  logic              eot_prev_reg;
  logic [CODE_W-1:0] cmd_reg;
  logic [EVT_W-1:0]  status_reg;
  logic [EVT_W-1:0]  status_next;
  logic [EVT_W-1:0]  mask_reg;
  logic [SETUP_W-1:0] setup_reg;
  logic [1:0]        ctrl_fs_reg;
  logic [DATA_W-1:0] count_reg;
  logic [DATA_W-1:0] bytes_reg;
  logic [DATA_W-1:0] budget_reg;
  logic [DATA_W-1:0] frame_cyc_reg;
  logic              atl_done_reg;
  logic              waiting_reg;
  logic [31:0]       wait_cnt_reg;
  logic              susp_prev_reg;
  logic              pend_prev_reg;
  logic [3:0]        pulse_cnt_reg;
  logic              irq_pin_reg;
  logic [DATA_W-1:0] dev_d_reg;
  logic              dev_oe_n_reg;
  logic              sof_reg;

  logic              s_cs_n;
  logic              s_rd_n;
  logic              s_wr_n;
  logic              s_a0;
  logic              s_eot_n;
  logic [DATA_W-1:0] s_data;
  logic              wr_done;
  logic              data_wr;
  hes_sel_t          wr_sel;
  hes_sel_t          rd_sel;
  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;
  logic              suspended;
  logic              int_eot;
  logic              ext_eot;
  logic              clk_ready;
  logic              pend;
  logic              irq_active;
  logic [DATA_W-1:0] rd_mux;

  // Pins pass two flops before any decode
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= {SYNC_W{1'b1}};
      sync2_reg <= {SYNC_W{1'b1}};
    end
    else
    begin
      sync1_reg <= {ext_eot_n_i, bus.cs_n, bus.rd_n, bus.wr_n, bus.a0,
                    bus.data};
      sync2_reg <= sync1_reg;
    end
  end

  assign {s_eot_n, s_cs_n, s_rd_n, s_wr_n, s_a0, s_data} = sync2_reg;

  // Commit on the trailing edge of the write strobe
  assign wr_done = s_wr_n && !wr_prev_reg && !s_cs_n;
  assign data_wr = wr_done && !s_a0 && |(cmd_reg & CMD_WRITE_FLAG);
  assign wr_sel  = data_wr ? hes_decode(cmd_reg) : HES_SEL_NONE;
  assign rd_sel  = hes_decode(cmd_reg);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_prev_reg  <= 1'b1;
      eot_prev_reg <= 1'b1;
      cmd_reg      <= 8'h00;
    end
    else
    begin
      wr_prev_reg  <= s_wr_n;
      eot_prev_reg <= s_eot_n;
      if (wr_done && s_a0)
        cmd_reg <= s_data[CODE_W-1:0];
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mask_reg    <= EVT_RESET;
      setup_reg   <= SETUP_RESET;
      ctrl_fs_reg <= CTRL_RESET;
      count_reg   <= 16'h0000;
      budget_reg  <= 16'h0000;
    end
    else
    begin
      case (wr_sel)
        HES_SEL_MASK:
          mask_reg <= s_data[EVT_W-1:0] & EVT_IMPL_MASK;
        HES_SEL_SETUP:  setup_reg   <= s_data[SETUP_W-1:0];
        HES_SEL_CTRL:   ctrl_fs_reg <= s_data[CTRL_FS_LSB +: 2];
        HES_SEL_COUNT:  count_reg   <= s_data;
        HES_SEL_BUDGET: budget_reg  <= s_data;
        default:        ;
      endcase
    end
  end

  // Suspend: requested by control write, taken when downstream is idle
  assign suspended = (ctrl_fs_reg == CTRL_FS_SUSP) && downstream_susp_i;

  // Byte counter raises the internal transfer end on a match
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bytes_reg <= 16'h0000;
    else if (wr_sel == HES_SEL_COUNT || int_eot)
      bytes_reg <= 16'h0000;
    else if (xfer_byte_i)
      bytes_reg <= bytes_reg + 16'h0001;
  end

  assign int_eot = xfer_byte_i && (count_reg != 16'h0000) &&
                   (bytes_reg + 16'h0001 == count_reg);
  assign ext_eot = !s_eot_n && eot_prev_reg;

  // Async list ready once per frame after the configured budget
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      frame_cyc_reg <= 16'h0000;
      atl_done_reg  <= 1'b0;
    end
    else if (frame_tick_i)
    begin
      frame_cyc_reg <= 16'h0000;
      atl_done_reg  <= 1'b0;
    end
    else
    begin
      if (frame_cyc_reg != 16'hffff)
        frame_cyc_reg <= frame_cyc_reg + 16'h0001;
      if (evt_set[EV_ASYNC])
        atl_done_reg <= 1'b1;
    end
  end

  // Clock ready wait; the timeout caps the wait at its longest
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      waiting_reg  <= 1'b0;
      wait_cnt_reg <= 32'h0000_0000;
    end
    else if (wakeup_i)
    begin
      waiting_reg  <= 1'b1;
      wait_cnt_reg <= 32'h0000_0000;
    end
    else if (clk_ready)
      waiting_reg <= 1'b0;
    else if (waiting_reg)
      wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
  end

  assign clk_ready = waiting_reg && (clk_stable_i ||
                     wait_cnt_reg == 32'(WAKE_MAX - 1));

  always_comb
  begin
    evt_set              = '0;
    evt_set[EV_CLKRDY]   = clk_ready;
    evt_set[EV_SUSPEND]  = suspended && !susp_prev_reg;
    evt_set[EV_OPR]      = opr_evt_i;
    evt_set[EV_DONE]     = int_eot || ext_eot;
    evt_set[EV_ASYNC]    = atl_pending_i && !atl_done_reg &&
                           frame_cyc_reg >= budget_reg;
    evt_set[EV_FRAME]    = frame_tick_i && !suspended;
  end

  assign evt_clr = (wr_sel == HES_SEL_STATUS) ?
                   s_data[EVT_W-1:0] : '0;
  // Set wins so an event in the clearing cycle survives
  assign status_next = ((status_reg & ~evt_clr) | evt_set) &
                       EVT_IMPL_MASK;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status_reg    <= EVT_RESET;
      susp_prev_reg <= 1'b0;
      sof_reg       <= 1'b0;
    end
    else
    begin
      status_reg    <= status_next;
      susp_prev_reg <= suspended;
      sof_reg       <= frame_tick_i && !suspended;
    end
  end

  // Interrupt pin
  assign pend = |(status_reg & mask_reg) && setup_reg[SETUP_GATE];
  assign irq_active = setup_reg[SETUP_EDGE] ?
                      (pulse_cnt_reg != 4'h0) : pend;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pend_prev_reg <= 1'b0;
      pulse_cnt_reg <= 4'h0;
      irq_pin_reg   <= 1'b1;
    end
    else
    begin
      pend_prev_reg <= pend;
      if (pend && !pend_prev_reg)
        pulse_cnt_reg <= 4'(IRQ_PULSE_CYC);
      else if (pulse_cnt_reg != 4'h0)
        pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
      irq_pin_reg <= setup_reg[SETUP_POL] ? irq_active : !irq_active;
    end
  end

  // Read path; unmapped codes read zero, reads have no side effect
  always_comb
  begin
    rd_mux = '0;
    case (rd_sel)
      HES_SEL_STATUS: rd_mux[EVT_W-1:0]   = status_reg;
      HES_SEL_MASK:   rd_mux[EVT_W-1:0]   = mask_reg;
      HES_SEL_SETUP:  rd_mux[SETUP_W-1:0] = setup_reg;
      HES_SEL_CTRL:   rd_mux[CTRL_FS_LSB +: 2] = ctrl_fs_reg;
      HES_SEL_COUNT:  rd_mux = count_reg;
      HES_SEL_BUDGET: rd_mux = budget_reg;
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dev_d_reg    <= 16'h0000;
      dev_oe_n_reg <= 1'b1;
    end
    else
    begin
      dev_d_reg    <= rd_mux;
      dev_oe_n_reg <= !(!s_cs_n && !s_rd_n && !s_a0 &&
                        !(|(cmd_reg & CMD_WRITE_FLAG)));
    end
  end

  assign bus.dev_d    = dev_d_reg;
  assign bus.dev_oe_n = dev_oe_n_reg;
  assign bus.irq_pin  = irq_pin_reg;
  assign sof_o        = sof_reg;
  assign suspended_o  = susp_prev_reg;
  assign status_o     = status_reg;

endmodule : hes_dev

/* rtl/hes_host.sv */
/*
  Processor end: runs one command phase then one data phase on the
  parallel bus for each request, and offers a one-shot acknowledge.
  Assumes the device samples strobes through two flops, so each phase
  lasts PHASE cycles to give it time to see and answer.
*/
module hes_host
  import hes_pkg::*;
#(
  parameter int unsigned PHASE = hes_pkg::PHASE_CYC
)
(
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  // Bus side
  hes_bus_if.host                        bus,
  // Request side
  input  wire logic                      req_valid_i,
  input  wire logic                      ack_all_i,
  input  wire logic [hes_pkg::CODE_W-1:0] req_code_i,
  input  wire logic [hes_pkg::DATA_W-1:0] req_wdata_i,
  output logic                           req_ready_o,
  output logic                           done_o,
  output logic [hes_pkg::DATA_W-1:0]     rdata_o,
  output logic                           irq_pin_o
);
  import hes_pkg::*;

  typedef enum logic [2:0] {
    HES_IDLE  = 3'b000,
    HES_C_SET = 3'b001,
    HES_C_STB = 3'b010,
    HES_C_HLD = 3'b011,
    HES_D_SET = 3'b100,
    HES_D_STB = 3'b101,
    HES_D_HLD = 3'b110
  } hes_hstate_t;

  hes_hstate_t       state_reg;
  logic [3:0]        phase_reg;
  logic [CODE_W-1:0] code_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] d_sync1_reg;
  logic [DATA_W-1:0] d_sync2_reg;
  logic [1:0]        irq_sync_reg;
  logic              done_reg;
  logic              phase_end;
  logic              is_write;

  assign phase_end   = (phase_reg == 4'(PHASE - 1));
  assign is_write    = |(code_reg & CMD_WRITE_FLAG);
  assign req_ready_o = (state_reg == HES_IDLE);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= HES_IDLE;
      phase_reg <= 4'h0;
      code_reg  <= 8'h00;
      wdata_reg <= 16'h0000;
    end
    else
    begin
      phase_reg <= (state_reg == HES_IDLE || phase_end) ? 4'h0 :
                   phase_reg + 4'h1;
      case (state_reg)
        HES_IDLE:
          if (req_valid_i)
          begin
            code_reg  <= req_code_i;
            wdata_reg <= req_wdata_i;
            state_reg <= HES_C_SET;
          end
          else if (ack_all_i)
          begin
            code_reg  <= CMD_STATUS_WR;
            wdata_reg <= ACK_ALL_VALUE;
            state_reg <= HES_C_SET;
          end
        HES_C_SET: if (phase_end) state_reg <= HES_C_STB;
        HES_C_STB: if (phase_end) state_reg <= HES_C_HLD;
        HES_C_HLD: if (phase_end) state_reg <= HES_D_SET;
        HES_D_SET: if (phase_end) state_reg <= HES_D_STB;
        HES_D_STB: if (phase_end) state_reg <= HES_D_HLD;
        HES_D_HLD: if (phase_end) state_reg <= HES_IDLE;
        default:   state_reg <= HES_IDLE;
      endcase
    end
  end

  // Read data and interrupt pin cross in through two flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      d_sync1_reg  <= 16'h0000;
      d_sync2_reg  <= 16'h0000;
      irq_sync_reg <= 2'b11;
      rdata_reg    <= 16'h0000;
      done_reg     <= 1'b0;
    end
    else
    begin
      d_sync1_reg  <= bus.data;
      d_sync2_reg  <= d_sync1_reg;
      irq_sync_reg <= {irq_sync_reg[0], bus.irq_pin};
      if (state_reg == HES_D_STB && phase_end && !is_write)
        rdata_reg <= d_sync2_reg;
      done_reg <= (state_reg == HES_D_HLD) && phase_end;
    end
  end

  // Pin drives from state; data held through hold phase
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus.cs_n      <= 1'b1;
      bus.rd_n      <= 1'b1;
      bus.wr_n      <= 1'b1;
      bus.a0        <= 1'b0;
      bus.host_d    <= 16'h0000;
      bus.host_oe_n <= 1'b1;
    end
    else
    begin
      bus.cs_n <= !(state_reg != HES_IDLE);
      bus.a0   <= (state_reg == HES_C_SET || state_reg == HES_C_STB ||
                   state_reg == HES_C_HLD);
      bus.wr_n <= !(state_reg == HES_C_STB ||
                    (state_reg == HES_D_STB && is_write));
      bus.rd_n <= !(state_reg == HES_D_STB && !is_write);
      bus.host_d <= (state_reg == HES_C_SET || state_reg == HES_C_STB ||
                     state_reg == HES_C_HLD) ?
                    {8'h00, code_reg} : wdata_reg;
      bus.host_oe_n <= !(state_reg == HES_C_SET || state_reg == HES_C_STB ||
                         state_reg == HES_C_HLD ||
                         (is_write && state_reg != HES_IDLE));
    end
  end

  assign done_o    = done_reg;
  assign rdata_o   = rdata_reg;
  assign irq_pin_o = irq_sync_reg[1];

endmodule : hes_host

/* verification/hes_monitor.sv */
/*
  Bus checker for the host event status pair.
  Assumes it watches the one hes_bus_if joining host and device ends.
*/
module hes_monitor
  import hes_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Bus
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        a0,
  input  wire logic [15:0] host_d,
  input  wire logic [15:0] dev_d,
  input  wire logic        dev_oe_n,
  input  wire logic        irq_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cmd_reg;
  logic [2:0] setup_reg;
  logic       seen_reg;
  logic       wr_q_reg;
  logic       act;

  // Pin level turned into active sense
  assign act = irq_pin ~^ setup_reg[2];

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q_reg  <= 1'b1;
      cmd_reg   <= 8'h00;
      setup_reg <= 3'h0;
      seen_reg  <= 1'b0;
    end
    else
    begin
      wr_q_reg <= wr_n;
      if (wr_n && !wr_q_reg && !cs_n && a0)
        cmd_reg <= host_d[7:0];
      if (wr_n && !wr_q_reg && !cs_n && !a0 && cmd_reg == 8'ha0)
      begin
        setup_reg <= host_d[2:0];
        seen_reg  <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_irq_idle_unset:
    assert property (!seen_reg |-> irq_pin) else $error("irq pin active");
  a_gate_off_idle:
    assert property (cs_n && !setup_reg[0] |-> irq_pin == !setup_reg[2])
    else $error("irq pin active with gate off");
  a_read_drive_time:
    assert property ($fell(rd_n) && !cs_n && !a0 && !cmd_reg[7]
                     |-> ##[2:6] !dev_oe_n) else $error("read not driven");
  a_drive_cause:
    assert property ($fell(dev_oe_n) |-> !cs_n && !a0 && !rd_n)
    else $error("device drove without read");
  a_drive_release:
    assert property ($rose(rd_n) |-> ##[2:6] dev_oe_n)
    else $error("device kept driving");
  a_write_no_drive:
    assert property (!wr_n |-> dev_oe_n) else $error("drive during write");
  a_status_resv_zero:
    assert property (!dev_oe_n && cmd_reg == 8'h24
                     |-> dev_d[15:7] == 9'h000 && !dev_d[3])
    else $error("status reserved bits set");
  a_mask_resv_zero:
    assert property (!dev_oe_n && cmd_reg == 8'h25 |-> dev_d[15:7] == 9'h000)
    else $error("mask reserved bits set");
  a_unmapped_zero:
    assert property (!dev_oe_n && cmd_reg == 8'h30 |-> dev_d == 16'h0000)
    else $error("unmapped read not zero");
  a_edge_pulse_len:
    assert property (cs_n && setup_reg[1] && $rose(act) |-> act[*4] ##1 !act)
    else $error("edge pulse length wrong");

  c_edge_pulse: cover property (setup_reg[1] && $rose(act));
  c_read_drive: cover property ($fell(dev_oe_n));
  c_irq_level:  cover property (!setup_reg[1] && setup_reg[0] && act);
endmodule : hes_monitor

/* verification/hes_test.sv */
/*
  Self-checking bench joining host and device ends over hes_bus_if.
  Assumes a 20 MHz clock and a shortened clock-ready wait.
*/
module hes_test;
  timeunit 1ns;
  timeprecision 1ns;
  import hes_pkg::*;

  localparam int WAKE = 50;
  typedef struct {logic [3:0] pl; logic [15:0] clr, e1, e2;} hes_row_t;
  // Pulses: 0 frame, 1 operational, 2 byte, 3 wake-up
  hes_row_t rows [4] = '{'{4'h3, 16'h0001, 16'h0011, 16'h0010},
                         '{4'h0, 16'h0010, 16'h0010, 16'h0000},
                         '{4'h4, 16'hff88, 16'h0004, 16'h0004},
                         '{4'h0, 16'h0004, 16'h0004, 16'h0000}};
  logic        sys_clk_i, rst_n_i, clk_stable_i, downstream_susp_i;
  logic        atl_pending_i, ext_eot_n_i, req_valid_i, ack_all_i;
  logic        req_ready_o, done_o, irq_pin_o, sof_o, suspended_o;
  logic [3:0]  pl;
  logic [7:0]  req_code_i;
  logic [15:0] req_wdata_i, rdata_o, rd_v;
  logic [6:0]  status_o;
  int          n_mismatch, checks_done, cycles;

  hes_bus_if u_hes_bus_if ();
  hes_dev #(.WAKE_MAX(WAKE)) u_hes_dev (.sys_clk_i, .rst_n_i,
    .bus(u_hes_bus_if), .wakeup_i(pl[3]), .clk_stable_i,
    .downstream_susp_i, .frame_tick_i(pl[0]), .opr_evt_i(pl[1]),
    .atl_pending_i, .xfer_byte_i(pl[2]), .ext_eot_n_i, .sof_o,
    .suspended_o, .status_o);
  hes_host u_hes_host (.sys_clk_i, .rst_n_i, .bus(u_hes_bus_if),
    .req_valid_i, .ack_all_i, .req_code_i, .req_wdata_i, .req_ready_o,
    .done_o, .rdata_o, .irq_pin_o);
  hes_monitor u_hes_monitor (.sys_clk_i, .rst_n_i,
    .cs_n(u_hes_bus_if.cs_n), .rd_n(u_hes_bus_if.rd_n),
    .wr_n(u_hes_bus_if.wr_n), .a0(u_hes_bus_if.a0),
    .host_d(u_hes_bus_if.host_d), .dev_d(u_hes_bus_if.dev_d),
    .dev_oe_n(u_hes_bus_if.dev_oe_n), .irq_pin(u_hes_bus_if.irq_pin));

  task automatic report_and_stop();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #5;
  endtask : cyc

  // Held until the take edge; done is polled once per cycle
  task automatic xfer(input logic [7:0] c, input logic [15:0] w,
                      input logic ack, output logic [15:0] r);
    int n;
    n = 0;
    cyc(1);
    req_code_i  = c;
    req_wdata_i = w;
    req_valid_i = !ack;
    ack_all_i   = ack;
    cyc(1);
    req_valid_i = 1'b0;
    ack_all_i   = 1'b0;
    if (ack) chk({15'h0000, req_ready_o}, 16'h0000);
    while (done_o !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n >= 200)
    begin
      n_mismatch++;
      report_and_stop();
    end
    r = rdata_o;
  endtask : xfer

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    xfer(c, d, 1'b0, rd_v);
  endtask : wr

  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    xfer(c, 16'h0000, 1'b0, rd_v);
    chk(rd_v, e);
  endtask : rdc

  task automatic pulse(input logic [3:0] m);
    pl = m;
    cyc(1);
    pl = 4'h0;
  endtask : pulse

  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Run is about 2200 cycles
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial
  begin
    {rst_n_i, clk_stable_i, downstream_susp_i, atl_pending_i} = 4'h0;
    {req_valid_i, ack_all_i, pl, req_code_i} = '0;
    {ext_eot_n_i, req_wdata_i} = {1'b1, 16'h0000};
    cyc(2);
    chk({9'h000, status_o}, 16'h0000);
    chk({15'h0000, u_hes_bus_if.irq_pin}, 16'h0001);
    rst_n_i = 1'b1;
    rdc(CMD_STATUS_RD, 16'h0000);
    rdc(CMD_MASK_RD, 16'h0000);
    rdc(CMD_SETUP_RD, 16'h0000);
    rdc(8'h30, 16'h0000);
    wr(8'ha2, 16'h0001);
    rdc(CMD_COUNT_RD, 16'h0001);
    foreach (rows[i])
    begin
      pulse(rows[i].pl);
      rdc(CMD_STATUS_RD, rows[i].e1);
      rdc(CMD_STATUS_RD, rows[i].e1);
      wr(CMD_STATUS_WR, rows[i].clr);
      rdc(CMD_STATUS_RD, rows[i].e2);
    end
    ext_eot_n_i = 1'b0;
    cyc(6);
    chk({9'h000, status_o}, 16'h0004);
    ext_eot_n_i = 1'b1;
    pulse(4'h8);
    cyc(WAKE + 5);
    chk({9'h000, status_o}, 16'h0044);
    xfer(8'h00, 16'h0000, 1'b1, rd_v);
    rdc(CMD_STATUS_RD, 16'h0000);
    clk_stable_i = 1'b1;
    pulse(4'h8);
    cyc(3);
    chk({9'h000, status_o}, 16'h0040);
    clk_stable_i = 1'b0;
    wr(CMD_STATUS_WR, 16'h0040);
    wr(8'h81, 16'h00c0);
    rdc(CMD_CTRL_RD, 16'h00c0);
    downstream_susp_i = 1'b1;
    cyc(3);
    chk({9'h000, status_o}, 16'h0020);
    chk({15'h0000, suspended_o}, 16'h0001);
    pulse(4'h1);
    chk({15'h0000, sof_o}, 16'h0000);
    cyc(2);
    chk({9'h000, status_o}, 16'h0020);
    wr(8'h81, 16'h0000);
    downstream_susp_i = 1'b0;
    xfer(8'h00, 16'h0000, 1'b1, rd_v);
    wr(8'h9b, 16'd20);
    rdc(CMD_BUDGET_RD, 16'h0014);
    // Raised after the tick so the old frame cannot claim the event
    pulse(4'h1);
    chk({15'h0000, sof_o}, 16'h0001);
    atl_pending_i = 1'b1;
    cyc(5);
    chk({9'h000, status_o}, 16'h0001);
    cyc(30);
    chk({9'h000, status_o}, 16'h0003);
    atl_pending_i = 1'b0;
    wr(CMD_STATUS_WR, 16'h0003);
    // Event lands on the very edge at which the clear is applied
    fork
      wr(CMD_STATUS_WR, 16'h0010);
      begin
        @(posedge u_hes_bus_if.wr_n iff !u_hes_bus_if.a0);
        cyc(2);
        pulse(4'h2);
      end
    join
    rdc(CMD_STATUS_RD, 16'h0010);
    wr(CMD_STATUS_WR, 16'h0010);
    wr(8'ha5, 16'h0000);
    wr(8'ha0, 16'h0001);
    pulse(4'h1);
    cyc(4);
    chk({15'h0000, u_hes_bus_if.irq_pin}, 16'h0001);
    wr(8'ha5, 16'h0001);
    cyc(2);
    chk({15'h0000, u_hes_bus_if.irq_pin}, 16'h0000);
    chk({15'h0000, irq_pin_o}, 16'h0000);
    wr(8'ha0, 16'h0000);
    cyc(2);
    chk({15'h0000, u_hes_bus_if.irq_pin}, 16'h0001);
    rdc(CMD_STATUS_RD, 16'h0001);
    wr(8'ha0, 16'h0007);
    wr(CMD_STATUS_WR, 16'h0001);
    pulse(4'h1);
    cyc(3);
    chk({15'h0000, u_hes_bus_if.irq_pin}, 16'h0001);
    cyc(6);
    chk({15'h0000, u_hes_bus_if.irq_pin}, 16'h0000);
    report_and_stop();
  end
endmodule : hes_test
